//--- nbps.sv
// Function
// - two operating points, each with own clock divisor and voltage code
// - disable bit stops all autonomous operating-point changes
// - all cores at or below threshold performance may trigger low point
// - all cores idle for the idle timer interval may trigger low point
// - enabled graphics activity level decides whether graphics blocks the low point
// - no operating-point change while DRAM sits in self-refresh
// - after entering low point, stay until low residency expires
// - after entering high point, stay until high residency expires
// - DMA traffic or DMA pin holds off transitions when configured
// - first step of a transition sets the in-flight flag
// - going high, raise supply first and wait before touching clocks
// - stop traffic, self-refresh, divisor, memory update, release, resume
// - going low, lower supply last after traffic resumes
// - force request moves to selected point, ignoring other criteria
// - forced move waits for no transition in flight, no DMA and no self-refresh
// - active point is readable status
// - self-refresh with selected idle condition lowers clock to reduced divisor
// - self-refresh exit restores point divisor, after or with DLL relock
// - gate inbound queue clock when idle, no traffic, hysteresis elapsed
// - gate DRAM clock when enabled, queue gated and in self-refresh
// - gate core interface clock when enabled, or when queue gated, or when that core is off
`timescale 1ns/1ps
`default_nettype none
`include "nbps_regs.svh"
module nbps #(
	parameter int NCORES = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core state
	input wire logic [NCORES*4-1:0] core_pstate,
	input wire logic [NCORES-1:0] core_idle,
	input wire logic [NCORES-1:0] core_off_idle,
	// graphics
	input wire logic gfx_enabled,
	input wire logic [2:0] gfx_activity,
	// traffic
	input wire logic dma_traffic,
	input wire logic dma_active_n,
	input wire logic nb_traffic,
	input wire logic queue_empty,
	// dram controller
	input wire logic dram_sr,
	output logic sr_req,
	input wire logic sr_ack,
	output logic mem_update_req,
	input wire logic mem_update_done,
	input wire logic dll_locked,
	// voltage regulator
	output nbps_pkg::nbps_vreq_t vreg,
	input wire logic volt_done,
	// clock control
	output logic [6:0] nb_div,
	output logic queue_gate,
	output logic dram_gate,
	output logic [NCORES-1:0] cif_gate
);
	import nbps_pkg::*;

	// ****************************************
	// register file
	// ****************************************
	nbps_ctrl_t ctrl;
	nbps_div_t divs;
	nbps_volt_t volt;
	nbps_tmr_t tmr;
	nbps_res_t res;
	nbps_fifo_t fifo;
	nbps_stat_t stat;
	nbps_state_t st;
	logic in_flight;
	logic low_active;
	logic div_low;
	logic target_low;
	logic clock_ramped;
	logic hit;
	logic [31:0] next_rdata;
	logic wr_en;

	// address decode and read mux
	always_comb begin
		hit = 1'b1;
		next_rdata = `NBPS_ZERO;
		if (paddr == `NBPS_OFF_CTRL) begin
			next_rdata = ctrl;
		end else if (paddr == `NBPS_OFF_DIV) begin
			next_rdata = divs;
		end else if (paddr == `NBPS_OFF_VOLT) begin
			next_rdata = volt;
		end else if (paddr == `NBPS_OFF_TMR) begin
			next_rdata = tmr;
		end else if (paddr == `NBPS_OFF_RES) begin
			next_rdata = res;
		end else if (paddr == `NBPS_OFF_FIFO) begin
			next_rdata = fifo;
		end else if (paddr == `NBPS_OFF_STAT) begin
			next_rdata = stat;
		end else begin
			hit = 1'b0;
		end
	end

	// zero wait state, error on unmapped
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en = psel & penable & pwrite & hit;

	// read data captured in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `NBPS_ZERO;
		end else if (psel && !penable) begin
			prdata <= next_rdata;
		end
	end

	// writable registers, reserved bits kept zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `NBPS_CTRL_RST;
			divs <= `NBPS_DIV_RST;
			volt <= `NBPS_VOLT_RST;
			tmr <= `NBPS_TMR_RST;
			res <= `NBPS_RES_RST;
			fifo <= `NBPS_FIFO_RST;
		end else if (wr_en) begin
			if (paddr == `NBPS_OFF_CTRL) begin
				ctrl <= pwdata;
				ctrl.rsvd <= '0;
			end else if (paddr == `NBPS_OFF_DIV) begin
				divs <= pwdata;
				divs.rsvd <= '0;
			end else if (paddr == `NBPS_OFF_VOLT) begin
				volt <= pwdata;
				volt.rsvd <= '0;
			end else if (paddr == `NBPS_OFF_TMR) begin
				tmr <= pwdata;
			end else if (paddr == `NBPS_OFF_RES) begin
				res <= pwdata;
			end else if (paddr == `NBPS_OFF_FIFO) begin
				fifo <= pwdata;
				fifo.rsvd <= '0;
			end
		end
	end

	// status view
	always_comb begin
		stat = `NBPS_ZERO;
		stat.transition_in_flight = in_flight;
		stat.low_point_active = low_active;
		stat.queue_gated = queue_gate;
		stat.dram_gated = dram_gate;
		stat.clock_ramped = clock_ramped;
	end

	// ****************************************
	// input conditioning
	// ****************************************
	logic dma_pin_meta;
	logic dma_pin;

	// two-stage synchroniser for the dma pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_pin_meta <= 1'b1;
			dma_pin <= 1'b1;
		end else begin
			dma_pin_meta <= dma_active_n;
			dma_pin <= dma_pin_meta;
		end
	end

	logic all_idle;
	logic thr_ok;
	logic dma_any;

	// per-core threshold test
	always_comb begin
		thr_ok = ctrl.core_threshold_enable;
		for (int i = 0; i < NCORES; i++) begin
			if (core_pstate[i*4 +: 4] < ctrl.core_threshold_state) begin
				thr_ok = 1'b0;
			end
		end
	end

	assign all_idle = &core_idle;
	assign dma_any = dma_traffic | ~dma_pin;

	// ****************************************
	// timers
	// ****************************************
	logic [15:0] idle_cnt;
	logic [15:0] res_cnt;
	logic [15:0] hyst_cnt;
	logic idle_ok;
	logic hyst_ok;
	logic fin;

	// idle interval, restarts on any running core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= '0;
		end else if (!all_idle) begin
			idle_cnt <= '0;
		end else if (idle_cnt < tmr.all_idle_timer) begin
			idle_cnt <= idle_cnt + `NBPS_CNT_ONE;
		end
	end
	assign idle_ok = all_idle && (idle_cnt >= tmr.all_idle_timer);

	// residency count loaded when a point is entered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_cnt <= '0;
		end else if (fin) begin
			res_cnt <= target_low ? res.low_point_min_residency
				: res.high_point_min_residency;
		end else if (res_cnt != '0) begin
			res_cnt <= res_cnt - `NBPS_CNT_ONE;
		end
	end

	// queue-empty hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hyst_cnt <= '0;
		end else if (!(all_idle && queue_empty && !nb_traffic)) begin
			hyst_cnt <= '0;
		end else if (hyst_cnt < tmr.queue_gate_hysteresis) begin
			hyst_cnt <= hyst_cnt + `NBPS_CNT_ONE;
		end
	end
	assign hyst_ok = hyst_cnt >= tmr.queue_gate_hysteresis;

	// ****************************************
	// transition decision
	// ****************************************
	logic gfx_ok;
	logic want_low;
	logic auto_start;
	logic force_start;
	logic start;
	logic go_low;

	assign gfx_ok = !gfx_enabled || (gfx_activity <= ctrl.graphics_activity_level);
	assign want_low = (thr_ok || idle_ok) && gfx_ok;

	// autonomous trigger with residency, dma and self-refresh holds
	assign auto_start = !ctrl.opp_auto_disable
		&& (res_cnt == '0)
		&& !(ctrl.dma_blocks_transition && dma_any)
		&& !dram_sr
		&& (low_active ? !want_low : want_low);

	// forced trigger, select one means low point
	assign force_start = (ctrl.force_point_select != low_active)
		&& !dma_any && !dram_sr;

	assign start = ctrl.force_point_request ? force_start : auto_start;
	assign go_low = ctrl.force_point_request ? ctrl.force_point_select : !low_active;

	// ****************************************
	// transition sequencer
	// ****************************************
	assign fin = ((st == NBPS_SRX) && !sr_ack && !target_low)
		|| ((st == NBPS_VDN) && volt_done);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= NBPS_IDLE;
			in_flight <= 1'b0;
			low_active <= 1'b0;
			div_low <= 1'b0;
			target_low <= 1'b0;
			sr_req <= 1'b0;
			mem_update_req <= 1'b0;
			vreg <= '0;
		end else begin
			case (st)
				NBPS_IDLE: begin
					if (start) begin
						in_flight <= 1'b1;
						target_low <= go_low;
						if (go_low) begin
							sr_req <= 1'b1;
							st <= NBPS_SRE;
						end else begin
							vreg.req <= 1'b1;
							vreg.code <= volt.high_point_voltage_code;
							st <= NBPS_VUP;
						end
					end
				end
				NBPS_VUP: begin
					if (volt_done) begin
						vreg.req <= 1'b0;
						sr_req <= 1'b1;
						st <= NBPS_SRE;
					end
				end
				NBPS_SRE: begin
					if (sr_ack) begin
						st <= NBPS_DIV;
					end
				end
				NBPS_DIV: begin
					div_low <= target_low;
					mem_update_req <= 1'b1;
					st <= NBPS_MEM;
				end
				NBPS_MEM: begin
					if (mem_update_done) begin
						mem_update_req <= 1'b0;
						sr_req <= 1'b0;
						st <= NBPS_SRX;
					end
				end
				NBPS_SRX: begin
					if (!sr_ack) begin
						if (target_low) begin
							vreg.req <= 1'b1;
							vreg.code <= volt.low_point_voltage_code;
							st <= NBPS_VDN;
						end else begin
							in_flight <= 1'b0;
							low_active <= 1'b0;
							st <= NBPS_IDLE;
						end
					end
				end
				NBPS_VDN: begin
					if (volt_done) begin
						vreg.req <= 1'b0;
						in_flight <= 1'b0;
						low_active <= 1'b1;
						st <= NBPS_IDLE;
					end
				end
				default: begin
					st <= NBPS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// clock ramping and gating
	// ****************************************
	logic ramp_idle;
	logic gate_ok;
	logic next_qgate;

	assign ramp_idle = ctrl.ramp_down_select || all_idle;

	// ramp flag follows self-refresh outside transitions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_ramped <= 1'b0;
		end else if (!clock_ramped) begin
			clock_ramped <= (st == NBPS_IDLE) && dram_sr && ramp_idle;
		end else if (!dram_sr && (ctrl.ramp_with_dll_relock || dll_locked)) begin
			clock_ramped <= 1'b0;
		end
	end

	// divisor output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nb_div <= '0;
		end else if (clock_ramped) begin
			nb_div <= divs.reduced_clock_divisor;
		end else begin
			nb_div <= div_low ? divs.low_point_clock_divisor
				: divs.high_point_clock_divisor;
		end
	end

	assign gate_ok = ctrl.nb_gate_enable && !ctrl.idle_gate_disable;
	assign next_qgate = gate_ok && !nb_traffic && queue_empty && all_idle && hyst_ok;

	// gate outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			queue_gate <= 1'b0;
			dram_gate <= 1'b0;
			cif_gate <= '0;
		end else begin
			queue_gate <= next_qgate;
			dram_gate <= ctrl.dram_gate_enable && next_qgate && dram_sr;
			for (int i = 0; i < NCORES; i++) begin
				cif_gate[i] <= ctrl.core_if_gate_enable || next_qgate || core_off_idle[i];
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_auto_disable_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_IDLE && ctrl.opp_auto_disable && !ctrl.force_point_request) |=> st == NBPS_IDLE)
		else $error("autonomous change while disabled");
	a_sr_blocks_start: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_IDLE && dram_sr) |=> st == NBPS_IDLE)
		else $error("transition started in self-refresh");
	a_residency_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_IDLE && res_cnt != '0 && !ctrl.force_point_request) |=> !in_flight)
		else $error("transition inside residency");
	a_flight_first: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_IDLE && start) |=> in_flight && !low_active == target_low)
		else $error("in-flight not set at start");
	a_supply_up_first: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_VUP && !volt_done) |=> !sr_req && nb_div == $past(nb_div))
		else $error("clocks touched before supply up");
	a_mem_in_refresh: assert property (@(posedge pclk) disable iff (!presetn)
		mem_update_req |-> sr_req && div_low == target_low)
		else $error("memory update outside self-refresh");
	a_supply_down_last: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_VDN) |-> vreg.req && !sr_req && !mem_update_req && target_low)
		else $error("supply lowered before traffic resumed");
	a_force_dma_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(st == NBPS_IDLE && ctrl.force_point_request && dma_any) |=> st == NBPS_IDLE)
		else $error("forced move during dma");
	a_ramp_divisor: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clock_ramped) |=> nb_div == divs.reduced_clock_divisor)
		else $error("reduced divisor not applied");
	a_dram_gate_deps: assert property (@(posedge pclk) disable iff (!presetn)
		dram_gate |-> queue_gate && $past(dram_sr))
		else $error("dram gated without queue gate");
	a_finish_status: assert property (@(posedge pclk) disable iff (!presetn)
		fin |=> !in_flight && low_active == $past(target_low))
		else $error("status not updated at finish");
endmodule
`default_nettype wire

//--- nbps_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far side: dram controller, regulator, phy
// ****************************************
module nbps_partner (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests from the block
	input wire logic sr_req,
	input wire logic mem_update_req,
	input wire nbps_pkg::nbps_vreq_t vreg,
	// scenario controls
	input wire logic stutter,
	input wire logic [3:0] lat,
	// answers
	output logic sr_ack,
	output logic mem_update_done,
	output logic volt_done,
	output logic dll_locked,
	output logic dram_sr
);
	import nbps_pkg::*;
	logic [3:0] c_sr, c_mu, c_v, c_d;
	// self-refresh seen by the block from either cause
	assign dram_sr = sr_ack | stutter;
	// each answer comes lat+1 cycles after its request, held while requested
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{c_sr, c_mu, c_v, c_d} <= '0;
			{sr_ack, mem_update_done, volt_done} <= '0;
			dll_locked <= 1'b1;
		end else begin
			c_sr <= (sr_req != sr_ack) ? c_sr + 4'h1 : 4'h0;
			c_mu <= (mem_update_req && !mem_update_done) ? c_mu + 4'h1 : 4'h0;
			c_v <= (vreg.req && !volt_done) ? c_v + 4'h1 : 4'h0;
			c_d <= (!dram_sr && !dll_locked) ? c_d + 4'h1 : 4'h0;
			if (c_sr >= lat) begin
				sr_ack <= sr_req;
			end
			mem_update_done <= mem_update_req && (mem_update_done || c_mu >= lat);
			volt_done <= vreg.req && (volt_done || c_v >= lat);
			// dll drops in self-refresh and relocks lat+1 cycles after exit
			dll_locked <= !dram_sr && (dll_locked || c_d >= lat);
		end
	end
endmodule
`default_nettype wire

//--- nbps_pkg.sv
`default_nettype none
package nbps_pkg;
	// control word layout
	typedef struct packed {
		logic [13:0] rsvd;
		logic [2:0] graphics_activity_level;
		logic [3:0] core_threshold_state;
		logic core_if_gate_enable;
		logic dram_gate_enable;
		logic idle_gate_disable;
		logic nb_gate_enable;
		logic ramp_with_dll_relock;
		logic ramp_down_select;
		logic force_point_select;
		logic force_point_request;
		logic dma_blocks_transition;
		logic core_threshold_enable;
		logic opp_auto_disable;
	} nbps_ctrl_t;
	// divisor word layout
	typedef struct packed {
		logic [10:0] rsvd;
		logic [6:0] reduced_clock_divisor;
		logic [6:0] low_point_clock_divisor;
		logic [6:0] high_point_clock_divisor;
	} nbps_div_t;
	// voltage code word layout
	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0] low_point_voltage_code;
		logic [7:0] high_point_voltage_code;
	} nbps_volt_t;
	// timer, residency and fifo ratio word layouts
	typedef struct packed {
		logic [15:0] queue_gate_hysteresis;
		logic [15:0] all_idle_timer;
	} nbps_tmr_t;
	typedef struct packed {
		logic [15:0] high_point_min_residency;
		logic [15:0] low_point_min_residency;
	} nbps_res_t;
	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0] mem_fifo_ratio_den;
		logic [7:0] mem_fifo_ratio_num;
	} nbps_fifo_t;
	// status word layout
	typedef struct packed {
		logic [26:0] rsvd;
		logic clock_ramped;
		logic dram_gated;
		logic queue_gated;
		logic low_point_active;
		logic transition_in_flight;
	} nbps_stat_t;
	// supply request toward the regulator
	typedef struct packed {
		logic req;
		logic [7:0] code;
	} nbps_vreq_t;
	// transition sequencer states
	typedef enum logic [6:0] {
		NBPS_IDLE = 7'h01,
		NBPS_VUP = 7'h02,
		NBPS_SRE = 7'h04,
		NBPS_DIV = 7'h08,
		NBPS_MEM = 7'h10,
		NBPS_SRX = 7'h20,
		NBPS_VDN = 7'h40
	} nbps_state_t;
endpackage
`default_nettype wire

//--- nbps_regs.svh
`ifndef NBPS_REGS_SVH
`define NBPS_REGS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define NBPS_OFF_CTRL 8'h00
`define NBPS_OFF_DIV 8'h04
`define NBPS_OFF_VOLT 8'h08
`define NBPS_OFF_TMR 8'h0c
`define NBPS_OFF_RES 8'h10
`define NBPS_OFF_FIFO 8'h14
`define NBPS_OFF_STAT 8'h18
// ****************************************
// reset values
// ****************************************
`define NBPS_CTRL_RST 32'h0000_0001
`define NBPS_DIV_RST 32'h0004_0804
`define NBPS_VOLT_RST 32'h0000_4030
`define NBPS_TMR_RST 32'h0040_0100
`define NBPS_RES_RST 32'h0100_0100
`define NBPS_FIFO_RST 32'h0000_0101
`define NBPS_ZERO 32'h0000_0000
`define NBPS_CNT_ONE 16'h0001
`endif

//--- nbps_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "nbps_regs.svh"
module nbps_tb;
	import nbps_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, sr_req, sr_ack, mem_update_req, mem_update_done;
	logic dll_locked, volt_done, dram_sr, queue_gate, dram_gate, stutter = 0;
	logic [7:0] core_pstate = '0, v_code;
	logic [1:0] core_idle = '0, core_off_idle = '0, cif_gate;
	logic gfx_enabled = 0, dma_traffic = 0, dma_active_n = 1, nb_traffic = 1, queue_empty = 0;
	logic [2:0] gfx_activity = '0;
	logic [3:0] lat = 4'h1;
	logic [6:0] nb_div, div_q;
	logic sr_q, v_q;
	nbps_vreq_t vreg;
	nbps_ctrl_t ctl;
	int cyc, t_sr, t_srf, t_v, t_div, mismatches, num_checks;
	logic [31:0] rv [8] = '{32'h1, 32'h0004_0804, 32'h4030, 32'h0040_0100, 32'h0100_0100,
		32'h0101, 32'h0, 32'h0};

	nbps #(.NCORES(2)) i_nbps (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_pstate(core_pstate),
		.core_idle(core_idle), .core_off_idle(core_off_idle), .gfx_enabled(gfx_enabled),
		.gfx_activity(gfx_activity), .dma_traffic(dma_traffic), .dma_active_n(dma_active_n),
		.nb_traffic(nb_traffic), .queue_empty(queue_empty), .dram_sr(dram_sr),
		.sr_req(sr_req), .sr_ack(sr_ack), .mem_update_req(mem_update_req),
		.mem_update_done(mem_update_done), .dll_locked(dll_locked), .vreg(vreg),
		.volt_done(volt_done), .nb_div(nb_div), .queue_gate(queue_gate),
		.dram_gate(dram_gate), .cif_gate(cif_gate));
	nbps_partner i_nbps_partner (.pclk(pclk), .presetn(presetn), .sr_req(sr_req),
		.mem_update_req(mem_update_req), .vreg(vreg), .stutter(stutter), .lat(lat),
		.sr_ack(sr_ack), .mem_update_done(mem_update_done), .volt_done(volt_done),
		.dll_locked(dll_locked), .dram_sr(dram_sr));

	// ****************************************
	// clock, edge timestamps, helpers
	// ****************************************
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		sr_q <= sr_req;
		v_q <= vreg.req;
		div_q <= nb_div;
		if (sr_req && !sr_q) t_sr <= cyc;
		if (!sr_req && sr_q) t_srf <= cyc;
		if (vreg.req && !v_q) t_v <= cyc;
		if (vreg.req && !v_q) v_code <= vreg.code;
		if (nb_div !== div_q) t_div <= cyc;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, answer taken at the edge that sees pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until the edge that samples pready high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task setctl;
		apb(1'b1, `NBPS_OFF_CTRL, ctl);
	endtask
	task stat(input int n);
		repeat (n) @(posedge pclk);
		apb(1'b0, `NBPS_OFF_STAT, '0);
	endtask
	// poll status low bits until they match
	task wait_stat(input logic [1:0] e);
		int n;
		n = 0;
		do begin
			stat(0);
			n++;
		end while (rd[1:0] !== e && n < 100);
		chk(rd[1:0], e);
	endtask
	task wait_div(input logic [6:0] e, input logic d);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (nb_div !== e && n < 40);
		chk(nb_div, e);
		if (d !== 1'bx) chk(dll_locked, d);
		@(posedge pclk);
	endtask
	task gates(input int n, input logic [3:0] e);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
		chk({queue_gate, dram_gate, cif_gate}, e);
		@(posedge pclk);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), '0);
			chk(rd, rv[i]);
			chk({31'h0, er}, {31'h0, i == 7});
		end
		chk(nb_div, 7'h04);
		apb(1'b1, `NBPS_OFF_STAT, 32'hffff_ffff);
		stat(0);
		chk(rd, 32'h0);
	endtask
	task t_disabled;
		apb(1'b1, `NBPS_OFF_DIV, 32'h0000_8605);
		apb(1'b1, `NBPS_OFF_VOLT, 32'h0000_5533);
		apb(1'b1, `NBPS_OFF_RES, 32'h0028_0028);
		apb(1'b1, `NBPS_OFF_TMR, 32'h0008_0014);
		apb(1'b1, `NBPS_OFF_FIFO, 32'h0000_0203);
		ctl = nbps_ctrl_t'(32'h1);
		ctl.core_threshold_enable = 1'b1;
		ctl.core_threshold_state = 4'h3;
		ctl.graphics_activity_level = 3'h2;
		setctl;
		core_pstate <= 8'h55;
		stat(30);
		chk(rd, 32'h0);
		chk(nb_div, 7'h05);
	endtask
	task t_low_high;
		lat <= 4'h6;
		ctl.opp_auto_disable = 1'b0;
		setctl;
		wait_stat(2'b01);
		wait_stat(2'b10);
		chk(nb_div, 7'h0c);
		chk({v_code, t_sr < t_div, t_srf < t_v}, {8'h55, 2'b11});
		core_pstate <= 8'h00;
		stat(0);
		chk(rd[1:0], 2'b10);
		wait_stat(2'b00);
		chk({nb_div, v_code, t_v < t_sr}, {7'h05, 8'h33, 1'b1});
		core_pstate <= 8'h55;
		stat(0);
		chk(rd[1:0], 2'b00);
		dma_active_n <= 1'b0;
		ctl.dma_blocks_transition = 1'b1;
		setctl;
		stat(60);
		chk(rd[1:0], 2'b00);
		dma_active_n <= 1'b1;
		dma_traffic <= 1'b1;
		stat(20);
		chk(rd[1:0], 2'b00);
		dma_traffic <= 1'b0;
		wait_stat(2'b10);
	endtask
	task t_force;
		ctl.opp_auto_disable = 1'b1;
		ctl.force_point_request = 1'b1;
		ctl.force_point_select = 1'b0;
		dma_traffic <= 1'b1;
		setctl;
		stat(30);
		chk(rd[1:0], 2'b10);
		dma_traffic <= 1'b0;
		wait_stat(2'b00);
		core_pstate <= 8'h00;
		ctl.force_point_select = 1'b1;
		setctl;
		wait_stat(2'b10);
		ctl.force_point_select = 1'b0;
		setctl;
		wait_stat(2'b00);
		ctl.force_point_request = 1'b0;
		ctl.opp_auto_disable = 1'b0;
		ctl.ramp_down_select = 1'b1;
		setctl;
	endtask
	task t_ramp;
		stutter <= 1'b1;
		wait_div(7'h02, 1'bx);
		core_pstate <= 8'h55;
		stat(30);
		chk(rd[4:0], 5'h10);
		core_pstate <= 8'h00;
		stutter <= 1'b0;
		wait_div(7'h05, 1'b1);
		ctl.ramp_with_dll_relock = 1'b1;
		setctl;
		stutter <= 1'b1;
		wait_div(7'h02, 1'bx);
		stutter <= 1'b0;
		wait_div(7'h05, 1'b0);
	endtask
	task t_idle;
		ctl.core_threshold_enable = 1'b0;
		setctl;
		gfx_enabled <= 1'b1;
		gfx_activity <= 3'h5;
		core_idle <= 2'b11;
		stat(60);
		chk(rd[1:0], 2'b00);
		core_idle <= 2'b00;
		gfx_activity <= 3'h1;
		stat(2);
		core_idle <= 2'b11;
		stat(0);
		chk(rd[1:0], 2'b00);
		wait_stat(2'b10);
	endtask
	task t_gate;
		ctl.opp_auto_disable = 1'b1;
		ctl.nb_gate_enable = 1'b1;
		ctl.dram_gate_enable = 1'b1;
		setctl;
		nb_traffic <= 1'b0;
		queue_empty <= 1'b1;
		gates(3, 4'h0);
		gates(12, 4'hb);
		stutter <= 1'b1;
		gates(3, 4'hf);
		nb_traffic <= 1'b1;
		gates(3, 4'h0);
		core_off_idle <= 2'b10;
		gates(3, 4'h2);
		ctl.core_if_gate_enable = 1'b1;
		setctl;
		gates(2, 4'h3);
		// idle gating disabled: queue and dram stay ungated
		ctl.idle_gate_disable = 1'b1;
		nb_traffic <= 1'b0;
		setctl;
		gates(12, 4'h3);
		stutter <= 1'b0;
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_disabled;
		t_low_high;
		t_force;
		t_ramp;
		t_idle;
		t_gate;
		tally_and_finish;
	end
	// watchdog far beyond the expected thousand or so cycles
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
